// file: timer0_pkg.sv
// Purpose: Shared constants and types for the 8-bit timer/counter.
// Assumes: i_clk is the oscillator clock; four clocks form one instruction.
// Notes: Field layout of cfg_t follows the configuration bit order.
package timer0_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 100;
  localparam int INSTR_PERIOD_NS = 400;
  localparam int CLKS_PER_INSTR = INSTR_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] INHIBIT_INSTR = 2'h2;

  // ==========================================================
  // Widths and values
  // ==========================================================
  localparam int COUNT_W = 8;
  localparam int PRESC_W = 8;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [PRESC_W-1:0] PRESC_RST = 8'h00;
  localparam logic [1:0] INHIBIT_NONE = 2'h0;
  localparam logic [1:0] INHIBIT_STEP = 2'h1;

  // Internal phase clocks, Gray coded
  typedef enum logic [1:0] {
    PH_ONE = 2'h0,
    PH_TWO = 2'h1,
    PH_THREE = 2'h3,
    PH_FOUR = 2'h2
  } phase_t;

  // Configuration bits from the core
  typedef struct packed {
    logic clock_source_select;
    logic count_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_rate_field;
  } cfg_t;

endpackage

// file: timer0_prescaler.sv
// Purpose: Shared divide-by-2^n prescaler for counter or watchdog.
// Assumes: i_step is a one-cycle event on the i_clk domain.
// Notes: Count is not visible outside, only the divided outputs.
`timescale 1ns/100ps
module timer0_prescaler (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_step,
  input wire logic i_clear,
  input wire logic [2:0] i_rate,
  // Divided outputs
  output logic o_level,
  output logic o_watchdog_pulse
);

  typedef struct packed {
    logic [timer0_pkg::PRESC_W-1:0] cnt;
  } presc_st_t;

  localparam int PRESC_W = timer0_pkg::PRESC_W;

  presc_st_t st_ff;
  presc_st_t nxt_st;
  logic [timer0_pkg::PRESC_W-1:0] mask;

  // ==========================================================
  // Ripple stages modelled as one synchronous binary count
  // ==========================================================
  always_comb begin
    nxt_st = st_ff;
    if (i_clear) begin
      nxt_st.cnt = timer0_pkg::PRESC_RST;
    end else if (i_step) begin
      nxt_st.cnt = st_ff.cnt + timer0_pkg::COUNT_ONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '{cnt: timer0_pkg::PRESC_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Stage output is a square wave: equal high and low times
  assign o_level = st_ff.cnt[i_rate];
  // Watchdog ratio is one stage shorter: 000 gives 1:1
  assign mask = PRESC_W'((9'h001 << i_rate) - 9'h001);
  assign o_watchdog_pulse = i_step && ((st_ff.cnt & mask) == mask);

  a_presc_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_clear |=> st_ff.cnt == timer0_pkg::PRESC_RST)
    else $error("prescaler not cleared");

endmodule

// file: timer0_counter.sv
// Purpose: 8-bit timer/counter with prescaler shared with the watchdog.
// Assumes: i_clk is the oscillator clock at 10 MHz, four per instruction.
// Notes: External input is a pin; it is synchronised before any use.
`timescale 1ns/100ps
module timer0_counter (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Core side
  input wire timer0_pkg::cfg_t i_cfg,
  input wire logic i_count_write,
  input wire logic [7:0] i_count_wdata,
  input wire logic i_flag_clear,
  input wire logic i_overflow_irq_enable,
  input wire logic i_sleep,
  // Watchdog side
  input wire logic i_watchdog_tick,
  output logic o_watchdog_prescaled,
  // Port bit four
  input wire logic i_porta_bit_four_pin,
  input wire logic i_porta_bit_four_latch,
  input wire logic i_porta_bit_four_dir_in,
  output logic o_porta_bit_four_out,
  output logic o_porta_bit_four_oe,
  // Status
  output logic [7:0] o_count_value,
  output logic o_overflow_flag,
  output logic o_irq_request
);

  typedef struct packed {
    logic [1:0] pin_sync;
    timer0_pkg::phase_t phase;
    logic ext_prev;
    logic samp;
    logic inc_pend;
    logic [1:0] inhibit;
    logic [7:0] count;
    logic flag;
    logic irq;
    logic watchdog_pulse;
    logic port_oe;
  } st_t;

  localparam st_t ST_RST = '{
    pin_sync: 2'h0, phase: timer0_pkg::PH_ONE, ext_prev: 1'b0,
    samp: 1'b0, inc_pend: 1'b0, inhibit: timer0_pkg::INHIBIT_NONE,
    count: timer0_pkg::COUNT_RST, flag: 1'b0, irq: 1'b0,
    watchdog_pulse: 1'b0, port_oe: 1'b0};

  st_t st_ff;
  st_t nxt_st;
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic ext_level;
  logic to_counter;
  logic direct;
  logic instr_tick;
  logic sample_en;
  logic src_step;
  logic presc_step;
  logic presc_level;
  logic presc_watchdog;
  logic level;
  logic inc;

  // ==========================================================
  // Reset release
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ==========================================================
  // Source selection and prescaler
  // ==========================================================
  // Inverting the level turns falling edges into rising ones
  assign ext_level = st_ff.pin_sync[1] ^ i_cfg.count_edge_select;
  assign to_counter = !i_cfg.prescaler_assign;
  assign direct = !i_cfg.clock_source_select && !to_counter;
  assign instr_tick = st_ff.phase == timer0_pkg::PH_FOUR;
  assign sample_en = (st_ff.phase == timer0_pkg::PH_TWO) ||
                     (st_ff.phase == timer0_pkg::PH_FOUR);
  assign src_step = i_cfg.clock_source_select ?
                    (ext_level && !st_ff.ext_prev) : instr_tick;
  assign presc_step = to_counter ? src_step : i_watchdog_tick;

  // Only divided outputs leave the prescaler; no software path
  timer0_prescaler i_timer0_prescaler (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_step(presc_step),
    .i_clear(i_count_write && to_counter),
    .i_rate(i_cfg.prescale_rate_field),
    .o_level(presc_level),
    .o_watchdog_pulse(presc_watchdog)
  );

  assign level = to_counter ? presc_level : ext_level;
  // Sleep gates sampling and the increment, so no overflow can occur there
  assign inc = st_ff.inc_pend && (st_ff.inhibit == timer0_pkg::INHIBIT_NONE)
               && !i_sleep;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin_sync = {st_ff.pin_sync[0], i_porta_bit_four_pin};
    nxt_st.ext_prev = ext_level;
    case (st_ff.phase)
      timer0_pkg::PH_ONE: nxt_st.phase = timer0_pkg::PH_TWO;
      timer0_pkg::PH_TWO: nxt_st.phase = timer0_pkg::PH_THREE;
      timer0_pkg::PH_THREE: nxt_st.phase = timer0_pkg::PH_FOUR;
      timer0_pkg::PH_FOUR: nxt_st.phase = timer0_pkg::PH_ONE;
      default: nxt_st.phase = timer0_pkg::PH_ONE;
    endcase
    if (sample_en && !i_sleep) begin
      nxt_st.samp = level;
    end
    // Increment lands one cycle after the sampling edge
    if (direct) begin
      nxt_st.inc_pend = instr_tick;
    end else begin
      nxt_st.inc_pend = sample_en && !i_sleep && level && !st_ff.samp;
    end
    if (instr_tick && (st_ff.inhibit != timer0_pkg::INHIBIT_NONE)) begin
      nxt_st.inhibit = st_ff.inhibit - timer0_pkg::INHIBIT_STEP;
    end
    if (i_count_write) begin
      nxt_st.count = i_count_wdata;
      nxt_st.inhibit = timer0_pkg::INHIBIT_INSTR;
    end else if (inc) begin
      nxt_st.count = st_ff.count + timer0_pkg::COUNT_ONE;
    end
    // Set beats a clear arriving in the same cycle
    nxt_st.flag = (st_ff.flag && !i_flag_clear) ||
      (inc && !i_count_write && st_ff.count == timer0_pkg::COUNT_MAX);
    nxt_st.irq = nxt_st.flag && i_overflow_irq_enable;
    nxt_st.watchdog_pulse = presc_watchdog && !to_counter;
    // Open drain: drives only a low level, never high
    nxt_st.port_oe = !i_porta_bit_four_dir_in &&
                     !i_porta_bit_four_latch;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_count_value = st_ff.count;
  assign o_overflow_flag = st_ff.flag;
  assign o_irq_request = st_ff.irq;
  assign o_watchdog_prescaled = st_ff.watchdog_pulse;
  assign o_porta_bit_four_out = 1'b0;
  assign o_porta_bit_four_oe = st_ff.port_oe;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  a_overflow_sets_flag: assert property (
    inc && !i_count_write && st_ff.count == timer0_pkg::COUNT_MAX
    |=> st_ff.flag && st_ff.count == timer0_pkg::COUNT_RST)
    else $error("wrap did not set flag");

  a_timer_rate: assert property (
    direct && instr_tick && !i_sleep && !i_count_write
    && st_ff.inhibit == timer0_pkg::INHIBIT_NONE ##1 !i_count_write
    && !i_sleep |=> st_ff.count == $past(st_ff.count, 2) + 8'h01)
    else $error("timer mode missed increment");

  // Quickest case is a write just before a decrement: six quiet cycles
  a_write_inhibit: assert property (
    i_count_write ##1 (!i_count_write)[*6]
    |-> st_ff.count == $past(st_ff.count, 5))
    else $error("increment during inhibit");

  a_counter_edge: assert property (
    i_cfg.clock_source_select && !to_counter && sample_en && !i_sleep
    && ext_level && !st_ff.samp |=> st_ff.inc_pend)
    else $error("external edge not counted");

  a_irq_masked: assert property (
    !i_overflow_irq_enable |=> !st_ff.irq || $past(i_overflow_irq_enable))
    else $error("masked request raised");

  a_flag_sticky: assert property (
    st_ff.flag && !i_flag_clear |=> st_ff.flag)
    else $error("flag dropped without clear");

  a_sleep_stops: assert property (
    i_sleep && !i_count_write |=> $stable(st_ff.count))
    else $error("count moved in sleep");

  a_sample_phase: assert property (
    st_ff.inc_pend && !direct
    |-> $past(st_ff.phase) inside {timer0_pkg::PH_TWO, timer0_pkg::PH_FOUR})
    else $error("sample off phase");

  a_open_drain: assert property (
    o_porta_bit_four_oe |-> !o_porta_bit_four_out
    && !$past(i_porta_bit_four_latch) && !$past(i_porta_bit_four_dir_in))
    else $error("port bit drives high");

  c_overflow: cover property (inc && st_ff.count == timer0_pkg::COUNT_MAX);
  c_counter_mode: cover property (i_cfg.clock_source_select && inc);
  c_write_inhibit: cover property (i_count_write ##1 st_ff.inc_pend);
  c_watchdog: cover property (st_ff.watchdog_pulse);

endmodule

// file: ext_count_source.sv
// Purpose: External count source driving the shared port pin.
// Assumes: Half period is given in bench clocks, two or more.
// Notes: Rests low between bursts; dropping i_run forces low at once, even mid-pulse.
`timescale 1ns/100ps
module ext_count_source (
  // Clock
  input wire logic i_clk,
  // Control
  input wire logic i_run,
  input wire logic [7:0] i_half,
  // Pin
  output logic o_level
);
  // ==========================================================
  // Toggle generator
  // ==========================================================
  logic [7:0] cnt_ff;
  initial begin
    o_level = 1'b0;
    cnt_ff = 8'h00;
  end
  // Each level lasts i_half clocks, so both levels get sampled
  always @(posedge i_clk) begin
    if (!i_run) begin
      o_level <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (cnt_ff == 8'h00) begin
      o_level <= ~o_level;
      cnt_ff <= i_half - 8'h01;
    end else begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule

// file: timer0_counter_with_shared_prescaler_tb.sv
// Purpose: Self-checking bench for the 8-bit timer/counter.
// Assumes: Four clocks per instruction; no internal parameters.
// Notes: Latencies are checked as intervals between count moves, except the sync delay, checked at a fixed time.
`timescale 1ns/100ps
module timer0_counter_with_shared_prescaler_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  timer0_pkg::cfg_t cfg = 6'h08;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic fclr = 1'b0;
  logic irq_en = 1'b0;
  logic sleep = 1'b0;
  logic wd_tick = 1'b0;
  logic latch = 1'b1;
  logic dir_in = 1'b1;
  logic run = 1'b0;
  logic [7:0] half = 8'h10;
  logic wd_pre, pd_out, pd_oe, flag, irq, src_level, pin;
  logic [7:0] count;
  int err_count = 0;
  int total_checks = 0;
  int wd_pulses = 0;
  int el;

  always #50 clk = ~clk;
  // Open-drain pull-down wins over the source
  assign pin = src_level & ~pd_oe;
  always @(posedge clk) if (wd_pre === 1'b1) wd_pulses++;

  timer0_counter i_timer0_counter (.i_clk(clk), .i_nrst(nrst),
    .i_cfg(cfg), .i_count_write(wr), .i_count_wdata(wdata),
    .i_flag_clear(fclr), .i_overflow_irq_enable(irq_en),
    .i_sleep(sleep), .i_watchdog_tick(wd_tick),
    .o_watchdog_prescaled(wd_pre), .i_porta_bit_four_pin(pin),
    .i_porta_bit_four_latch(latch), .i_porta_bit_four_dir_in(dir_in),
    .o_porta_bit_four_out(pd_out), .o_porta_bit_four_oe(pd_oe),
    .o_count_value(count), .o_overflow_flag(flag), .o_irq_request(irq));
  ext_count_source i_ext_count_source (.i_clk(clk), .i_run(run),
    .i_half(half), .o_level(src_level));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_cfg(input logic [5:0] v);
    @(posedge clk);
    cfg <= v;
  endtask
  task automatic write_count(input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    tick(1);
  endtask
  // Clocks until the count moves, bounded
  task automatic wait_move(output int n);
    logic [7:0] old;
    old = count;
    n = 0;
    while (count === old) begin
      tick(1);
      n++;
      if (n > 1100) begin
        err_count++;
        $display("mismatch count_move expected change seen none");
        results();
      end
    end
  endtask
  task automatic pulse_wd();
    @(posedge clk);
    wd_tick <= 1'b1;
    @(posedge clk);
    wd_tick <= 1'b0;
  endtask

  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    tick(5);
    check("count_rst", count, 8'h00);
    check("flag_rst", flag, 1'b0);
    // Write blocks increments, then wrap sets the flag
    write_count(8'hfe);
    check("count_wr", count, 8'hfe);
    wait_move(el);
    check("inhibit", el >= 7, 1'b1);
    check("count_ff", count, 8'hff);
    wait_move(el);
    check("instr_step", 16'(el), 16'h4);
    check("wrap", count, 8'h00);
    check("flag_set", flag, 1'b1);
    check("irq_masked", irq, 1'b0);
    @(posedge clk);
    irq_en <= 1'b1;
    tick(12);
    check("irq_on", irq, 1'b1);
    check("flag_held", flag, 1'b1);
    @(posedge clk);
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    tick(2);
    check("flag_clr", flag, 1'b0);
    check("irq_off", irq, 1'b0);
    // Every ratio, unprescaled first
    for (int k = 0; k < 9; k++) begin
      set_cfg(k == 0 ? 6'h08 : 6'(k - 1));
      write_count(8'h00);
      wait_move(el);
      wait_move(el);
      check("ratio", 16'(el), 16'(4 << k));
    end
    set_cfg(6'h08);
    @(posedge clk);
    sleep <= 1'b1;
    tick(3);
    el = count;
    tick(40);
    check("sleep_hold", count, 16'(el));
    @(posedge clk);
    sleep <= 1'b0;
    // External edges, rising then falling
    for (int e = 0; e < 2; e++) begin
      set_cfg(e == 0 ? 6'h28 : 6'h38);
      tick(10);
      write_count(8'h00);
      tick(10);
      @(posedge clk);
      run <= 1'b1;
      tick(3);
      check("sync_delay", count, 8'h00);
      tick(11);
      check("edge_sel", count, e == 0 ? 8'h01 : 8'h00);
      tick(82);
      run <= 1'b0;
      tick(20);
      check("ext_count", count, 8'h03);
    end
    // Prescaled external input, ratio 1:2
    set_cfg(6'h20);
    tick(10);
    write_count(8'h00);
    tick(10);
    @(posedge clk);
    half <= 8'h03;
    run <= 1'b1;
    tick(36);
    run <= 1'b0;
    tick(20);
    check("ext_presc", count, 8'h03);
    // Watchdog gets the prescaler only when assigned
    set_cfg(6'h09);
    tick(2);
    wd_pulses = 0;
    repeat (4) pulse_wd();
    tick(4);
    check("wd_div", 16'(wd_pulses), 16'h2);
    set_cfg(6'h01);
    tick(2);
    wd_pulses = 0;
    repeat (4) pulse_wd();
    tick(4);
    check("wd_none", 16'(wd_pulses), 16'h0);
    // Open-drain port bit
    @(posedge clk);
    dir_in <= 1'b0;
    latch <= 1'b0;
    tick(3);
    check("pin_oe", pd_oe, 1'b1);
    check("pin_out", pd_out, 1'b0);
    @(posedge clk);
    dir_in <= 1'b1;
    tick(3);
    check("pin_rel", pd_oe, 1'b0);
    results();
  end
endmodule
